// ===== shared/ipw_consts.vh
// constants for the interrupt priority and wake controller
// assumes a 32-bit register port and 32 flag positions grouped by vector
`ifndef IPW_CONSTS_VH
`define IPW_CONSTS_VH

`define IPW_NSRC 32
`define IPW_NVEC 10
`define IPW_AW 5

// register offsets
`define IPW_REG_FLAG 5'h00
`define IPW_REG_ENABLE 5'h04
`define IPW_REG_LEVEL 5'h08
`define IPW_REG_STATUS 5'h0c
`define IPW_REG_LIST 5'h10
`define IPW_REG_STBY 5'h14

// reset values
`define IPW_RST_ENABLE 32'h00000000
`define IPW_RST_LEVEL 10'h000
`define IPW_RST_POL 6'h00
// pins park at the inactive level of the default polarity so reset fakes no wake
`define IPW_RST_PIN 6'h3f

// priority levels
`define IPW_LVL_NONE 2'h0
`define IPW_LVL_L 2'h1
`define IPW_LVL_H 2'h2
`define IPW_LVL_X 2'h3

// standby states
`define IPW_SB_RUN 2'h0
`define IPW_SB_HALT 2'h1
`define IPW_SB_HOLD 2'h2
`define IPW_SB_XHOLD 2'h3

// flag positions of each vector
`define IPW_VM0 32'h00000001
`define IPW_VM1 32'h00000002
`define IPW_VM2 32'h0000003c
`define IPW_VM3 32'h000003c0
`define IPW_VM4 32'h00000c00
`define IPW_VM5 32'h00007000
`define IPW_VM6 32'h000f8000
`define IPW_VM7 32'h00700000
`define IPW_VM8 32'h1f800000
`define IPW_VM9 32'he0000000

// sources that also end standby
`define IPW_SRC_RC1 5
`define IPW_SRC_BT 7
`define IPW_SRC_RC2 9
`define IPW_SRC_PORT0 29

// pins 0,1,2,4,5 release hold; pin 3 does not
`define IPW_PIN_WAKE_MASK 6'h37

// vectors below this index use the highest level as their upper level
`define IPW_XVEC_LIMIT 4'h2
// low bits of every vector address
`define IPW_VEC_LOW 3'h3

// status and standby field positions
`define IPW_ST_VEC_LSB 0
`define IPW_ST_REQ 4
`define IPW_ST_ISV_LSB 5
`define IPW_ST_SB_LSB 8
`define IPW_SB_POL_LSB 8
`define IPW_SB_MODE_LSB 0

`endif

// ===== verilog/ipw_arb.v
// priority arbiter across the vectors
// assumes per-vector levels already resolved and a live in-service level
`timescale 1ns/1ps
`include "ipw_consts.vh"

module ipw_arb #(
  parameter NVEC = `IPW_NVEC
) (
  input wire [NVEC-1:0] pend,
  input wire [2*NVEC-1:0] lvl,
  input wire [1:0] cur,
  output reg req,
  output reg [3:0] vec,
  output reg [1:0] level
);

  integer i;

  // walk downward so that on equal level the smaller index overwrites
  always @* begin
    req = 1'b0;
    vec = 4'h0;
    level = `IPW_LVL_NONE;
    for (i = NVEC - 1; i >= 0; i = i - 1) begin
      if (pend[i] && (lvl[2*i +: 2] > cur) && (lvl[2*i +: 2] >= level)) begin
        req = 1'b1;
        vec = i[3:0];
        level = lvl[2*i +: 2];
      end
    end
  end

endmodule

// ===== verilog/ipw_ctrl.v
// interrupt priority controller with standby wake logic
// assumes one-cycle source pulses on CLK, async external pins, and a core
// that acknowledges a vector and signals each return
`timescale 1ns/1ps
`include "ipw_consts.vh"

module ipw_ctrl #(
  parameter NSRC = `IPW_NSRC,
  parameter NVEC = `IPW_NVEC
) (
  input wire CLK,
  input wire RST_B,
  input wire [`IPW_AW-1:0] ADDR,
  input wire [31:0] WDATA,
  input wire WE,
  input wire RE,
  output wire [31:0] RDATA,
  input wire [NSRC-1:0] SRC_EVT,
  input wire [5:0] EXT_PIN,
  output wire IRQ_REQ,
  output wire [3:0] IRQ_VEC,
  output wire [15:0] IRQ_ADDR,
  output wire [1:0] IRQ_LEVEL,
  input wire IRQ_ACK,
  input wire IRQ_RETI,
  output wire CPU_STOP,
  output wire PERIPH_STOP,
  output wire MAIN_OSC_STOP,
  output wire XTAL_OSC_STOP,
  output wire BT_IR_STOP,
  output wire WAKE
);

  // register state
  reg [NSRC-1:0] flag_q;
  reg [NSRC-1:0] flag_d;
  reg [NSRC-1:0] enable_q;
  reg [NVEC-1:0] lvsel_q;
  reg [NSRC-1:0] list_q;
  reg [5:0] pol_q;
  reg [31:0] rdata_q;
  reg [31:0] rdata_d;

  // in-service levels, one bit per level, low bit is level low
  reg [2:0] insvc_q;
  reg [2:0] insvc_d;
  reg [1:0] cur_lvl;

  // core handshake
  reg irq_req_q;
  reg [3:0] irq_vec_q;
  reg [1:0] irq_lvl_q;
  reg [15:0] irq_addr_q;

  // standby
  reg [1:0] sb_q;
  reg [1:0] sb_d;
  reg wake_q;
  reg wake_d;
  reg [5:0] pin_s1_q;
  reg [5:0] pin_s2_q;

  wire [NVEC-1:0] pend;
  wire [2*NVEC-1:0] vec_lvl;
  wire arb_req;
  wire [3:0] arb_vec;
  wire [1:0] arb_lvl;
  wire wr_flag;
  wire wr_enable;
  wire wr_level;
  wire wr_stby;
  wire [NSRC-1:0] live;
  wire take;
  wire pin_hit;
  wire hold_wake;
  wire xhold_wake;

  assign wr_flag = WE && (ADDR == `IPW_REG_FLAG);
  assign wr_enable = WE && (ADDR == `IPW_REG_ENABLE);
  assign wr_level = WE && (ADDR == `IPW_REG_LEVEL);
  assign wr_stby = WE && (ADDR == `IPW_REG_STBY);
  assign live = flag_q & enable_q;

  // flag positions that share one vector
  function [31:0] vmask;
    input [3:0] idx;
    begin
      case (idx)
        4'h0: vmask = `IPW_VM0;
        4'h1: vmask = `IPW_VM1;
        4'h2: vmask = `IPW_VM2;
        4'h3: vmask = `IPW_VM3;
        4'h4: vmask = `IPW_VM4;
        4'h5: vmask = `IPW_VM5;
        4'h6: vmask = `IPW_VM6;
        4'h7: vmask = `IPW_VM7;
        4'h8: vmask = `IPW_VM8;
        4'h9: vmask = `IPW_VM9;
        default: vmask = 32'h00000000;
      endcase
    end
  endfunction

  // per-vector request and level
  genvar gv;
  generate
    for (gv = 0; gv < NVEC; gv = gv + 1) begin : g_vec
      localparam integer VI = gv;
      wire [3:0] vidx = VI[3:0];
      wire upper_x = (vidx < `IPW_XVEC_LIMIT);
      // several sources collapse onto one vector request
      assign pend[gv] = |(live & vmask(vidx));
      // the upper choice is highest for the first two vectors, high for the rest
      assign vec_lvl[2*gv +: 2] = !lvsel_q[gv] ? `IPW_LVL_L :
        (upper_x ? `IPW_LVL_X : `IPW_LVL_H);
    end
  endgenerate

  // level codes are ordered numerically so a compare ranks them
  always @* begin
    if (insvc_q[2]) begin
      cur_lvl = `IPW_LVL_X;
    end else if (insvc_q[1]) begin
      cur_lvl = `IPW_LVL_H;
    end else if (insvc_q[0]) begin
      cur_lvl = `IPW_LVL_L;
    end else begin
      cur_lvl = `IPW_LVL_NONE;
    end
  end

  ipw_arb #(
    .NVEC(NVEC)
  ) u_arb (
    .pend(pend),
    .lvl(vec_lvl),
    .cur(cur_lvl),
    .req(arb_req),
    .vec(arb_vec),
    .level(arb_lvl)
  );

  // a request is taken only while offered; the core must not ack otherwise
  assign take = IRQ_ACK && irq_req_q;

  // flags: hardware set wins over a software clear in the same cycle
  always @* begin
    flag_d = flag_q;
    if (wr_flag) begin
      flag_d = flag_q & ~WDATA[NSRC-1:0];
    end
    flag_d = flag_d | SRC_EVT;
  end

  // in-service stack as a level bitmask; nesting is strictly upward
  always @* begin
    insvc_d = insvc_q;
    if (IRQ_RETI) begin
      // drop only the top level, which restores the one below it
      if (insvc_q[2]) begin
        insvc_d[2] = 1'b0;
      end else if (insvc_q[1]) begin
        insvc_d[1] = 1'b0;
      end else begin
        insvc_d[0] = 1'b0;
      end
    end else if (take) begin
      case (irq_lvl_q)
        `IPW_LVL_L: insvc_d[0] = 1'b1;
        `IPW_LVL_H: insvc_d[1] = 1'b1;
        `IPW_LVL_X: insvc_d[2] = 1'b1;
        default: insvc_d = insvc_q;
      endcase
    end
  end

  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      flag_q <= {NSRC{1'b0}};
      enable_q <= `IPW_RST_ENABLE;
      lvsel_q <= `IPW_RST_LEVEL;
      pol_q <= `IPW_RST_POL;
      insvc_q <= 3'h0;
    end else begin
      flag_q <= flag_d;
      insvc_q <= insvc_d;
      if (wr_enable) begin
        enable_q <= WDATA[NSRC-1:0];
      end
      if (wr_level) begin
        lvsel_q <= WDATA[NVEC-1:0];
      end
      if (wr_stby) begin
        pol_q <= WDATA[`IPW_SB_POL_LSB +: 6];
      end
    end
  end

  // offer to the core; masked on the ack or return cycle to avoid a double take
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      irq_req_q <= 1'b0;
      irq_vec_q <= 4'h0;
      irq_lvl_q <= `IPW_LVL_NONE;
      irq_addr_q <= 16'h0000;
    end else begin
      irq_req_q <= arb_req && !IRQ_ACK && !IRQ_RETI;
      if (arb_req) begin
        irq_vec_q <= arb_vec;
        irq_lvl_q <= arb_lvl;
        irq_addr_q <= {9'h000, arb_vec, `IPW_VEC_LOW};
      end
    end
  end

  // source list for the vector just taken
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      list_q <= {NSRC{1'b0}};
    end else if (take) begin
      list_q <= live & vmask(irq_vec_q);
    end
  end

  // pins come from outside, two flops before use
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pin_s1_q <= `IPW_RST_PIN;
      pin_s2_q <= `IPW_RST_PIN;
    end else begin
      pin_s1_q <= EXT_PIN;
      pin_s2_q <= pin_s1_q;
    end
  end

  // level-sensitive, so a pin held active keeps releasing; pin three never wakes
  assign pin_hit = |(~(pin_s2_q ^ pol_q) & `IPW_PIN_WAKE_MASK);
  assign hold_wake = pin_hit || SRC_EVT[`IPW_SRC_PORT0];
  assign xhold_wake = hold_wake || SRC_EVT[`IPW_SRC_BT] ||
    SRC_EVT[`IPW_SRC_RC1] || SRC_EVT[`IPW_SRC_RC2];

  // standby state; reset pin low returns to run asynchronously
  always @* begin
    sb_d = sb_q;
    wake_d = 1'b0;
    case (sb_q)
      `IPW_SB_RUN: begin
        if (wr_stby) begin
          sb_d = WDATA[`IPW_SB_MODE_LSB +: 2];
        end
      end
      `IPW_SB_HALT: begin
        if (arb_req) begin
          sb_d = `IPW_SB_RUN;
          wake_d = 1'b1;
        end
      end
      `IPW_SB_HOLD: begin
        if (hold_wake) begin
          sb_d = `IPW_SB_RUN;
          wake_d = 1'b1;
        end
      end
      `IPW_SB_XHOLD: begin
        if (xhold_wake) begin
          sb_d = `IPW_SB_RUN;
          wake_d = 1'b1;
        end
      end
      default: begin
        sb_d = `IPW_SB_RUN;
      end
    endcase
  end

  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sb_q <= `IPW_SB_RUN;
      wake_q <= 1'b0;
    end else begin
      sb_q <= sb_d;
      wake_q <= wake_d;
    end
  end

  // halt stops only the core; oscillators stop only in the hold states
  assign CPU_STOP = (sb_q != `IPW_SB_RUN);
  assign PERIPH_STOP = (sb_q == `IPW_SB_HOLD) || (sb_q == `IPW_SB_XHOLD);
  assign MAIN_OSC_STOP = PERIPH_STOP;
  assign XTAL_OSC_STOP = (sb_q == `IPW_SB_HOLD);
  // crystal hold keeps the base timer and receivers alive for their wake events
  assign BT_IR_STOP = (sb_q == `IPW_SB_HOLD);
  assign WAKE = wake_q;

  // register read, data one cycle after the strobe
  always @* begin
    rdata_d = 32'h00000000;
    case (ADDR)
      `IPW_REG_FLAG: rdata_d[NSRC-1:0] = flag_q;
      `IPW_REG_ENABLE: rdata_d[NSRC-1:0] = enable_q;
      `IPW_REG_LEVEL: rdata_d[NVEC-1:0] = lvsel_q;
      `IPW_REG_STATUS: begin
        rdata_d[`IPW_ST_VEC_LSB +: 4] = irq_vec_q;
        rdata_d[`IPW_ST_REQ] = irq_req_q;
        rdata_d[`IPW_ST_ISV_LSB +: 3] = insvc_q;
        rdata_d[`IPW_ST_SB_LSB +: 2] = sb_q;
      end
      `IPW_REG_LIST: rdata_d[NSRC-1:0] = list_q;
      `IPW_REG_STBY: begin
        rdata_d[`IPW_SB_MODE_LSB +: 2] = sb_q;
        rdata_d[`IPW_SB_POL_LSB +: 6] = pol_q;
      end
      default: rdata_d = 32'h00000000;
    endcase
  end

  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rdata_q <= 32'h00000000;
    end else if (RE) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 32'h00000000;
    end
  end

  assign RDATA = rdata_q;
  assign IRQ_REQ = irq_req_q;
  assign IRQ_VEC = irq_vec_q;
  assign IRQ_ADDR = irq_addr_q;
  assign IRQ_LEVEL = irq_lvl_q;

endmodule

// ===== sim/ipw_ctrl_properties.sv
// checker for the interrupt priority and wake controller
// assumes it is bound to ipw_ctrl and sees its ports only
`timescale 1ns/1ps
module ipw_ctrl_properties #(
  parameter NSRC = 32
) (
  input wire CLK,
  input wire RST_B,
  input wire [NSRC-1:0] SRC_EVT,
  input wire IRQ_REQ,
  input wire [3:0] IRQ_VEC,
  input wire [15:0] IRQ_ADDR,
  input wire [1:0] IRQ_LEVEL,
  input wire IRQ_ACK,
  input wire CPU_STOP,
  input wire PERIPH_STOP,
  input wire MAIN_OSC_STOP,
  input wire XTAL_OSC_STOP,
  input wire BT_IR_STOP,
  input wire WAKE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // crystal hold: peripherals stopped but the crystal left running
  wire xh = PERIPH_STOP && !XTAL_OSC_STOP;
  a_addr_map: assert property (IRQ_REQ |-> IRQ_ADDR == {9'h0, IRQ_VEC, 3'h3} && IRQ_VEC <= 4'h9)
    else $error("vector address off its index");
  a_level_set: assert property (IRQ_REQ |-> IRQ_LEVEL != 2'h0 && (IRQ_LEVEL != 2'h3 || IRQ_VEC < 4'h2))
    else $error("offered level not allowed");
  a_ack_drop: assert property (IRQ_ACK && IRQ_REQ |=> !IRQ_REQ)
    else $error("request stands after ack");
  a_halt_osc: assert property (CPU_STOP && !PERIPH_STOP |-> !MAIN_OSC_STOP && !XTAL_OSC_STOP)
    else $error("halt stopped an oscillator");
  a_xhold_run: assert property (xh |-> CPU_STOP && MAIN_OSC_STOP && !BT_IR_STOP)
    else $error("crystal hold stop set wrong");
  a_port_wake: assert property (PERIPH_STOP && SRC_EVT[29] |=> !CPU_STOP && WAKE)
    else $error("port source did not wake");
  a_bt_wake: assert property (xh && SRC_EVT[7] |=> WAKE && !PERIPH_STOP)
    else $error("base timer did not wake");
  a_rc_wake: assert property (xh && (SRC_EVT[5] || SRC_EVT[9]) |=> WAKE)
    else $error("receiver did not wake");
  a_wake_once: assert property ($rose(WAKE) |=> !WAKE && !CPU_STOP)
    else $error("wake pulse too long");
endmodule

// ===== sim/ipw_core_model.sv
// model of the core: takes offered vectors and returns from them
// assumes the bench steers it through auto_ack, ack_dly and ret_cmd
`timescale 1ns/1ps
module ipw_core_model (
  input wire clk,
  input wire rst_b,
  input wire irq_req,
  input wire auto_ack,
  input wire [3:0] ack_dly,
  input wire ret_cmd,
  output reg irq_ack,
  output reg irq_reti
);
  reg [3:0] wait_q;
  // ack only while a request stands and never beside a return, which would win
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_ack <= 1'b0;
      irq_reti <= 1'b0;
      wait_q <= 4'h0;
    end else begin
      irq_ack <= 1'b0;
      irq_reti <= ret_cmd;
      if (irq_req && auto_ack && !irq_ack && !ret_cmd) begin
        if (wait_q >= ack_dly) begin
          irq_ack <= 1'b1;
          wait_q <= 4'h0;
        end else
          wait_q <= wait_q + 4'h1;
      end else if (!irq_req) begin
        wait_q <= 4'h0;
      end
    end
  end
endmodule

// ===== sim/ipw_ctrl_tb.sv
// bench for the interrupt controller: plays software, sources and pins
// assumes the core model answers offers when told
`timescale 1ns/1ps
`include "ipw_consts.vh"
module ipw_ctrl_tb;
  reg CLK, RST_B, WE, RE, auto, ret;
  reg [3:0] dly;
  reg [4:0] ADDR;
  reg [31:0] WDATA, SRC_EVT;
  reg [5:0] EXT_PIN;
  wire [31:0] RDATA;
  wire IRQ_REQ, IRQ_ACK, IRQ_RETI, CPU_STOP, PERIPH_STOP, MAIN_OSC_STOP, XTAL_OSC_STOP, BT_IR_STOP, WAKE;
  wire [3:0] IRQ_VEC;
  wire [15:0] IRQ_ADDR;
  wire [1:0] IRQ_LEVEL;
  wire [4:0] stops = {CPU_STOP, PERIPH_STOP, MAIN_OSC_STOP, XTAL_OSC_STOP, BT_IR_STOP};
  integer failures, cmp_count, i;
  ipw_ctrl u_dut (.CLK, .RST_B, .ADDR, .WDATA, .WE, .RE, .RDATA, .SRC_EVT, .EXT_PIN, .IRQ_REQ, .IRQ_VEC,
    .IRQ_ADDR, .IRQ_LEVEL, .IRQ_ACK, .IRQ_RETI, .CPU_STOP, .PERIPH_STOP, .MAIN_OSC_STOP, .XTAL_OSC_STOP,
    .BT_IR_STOP, .WAKE);
  ipw_core_model u_core (.clk(CLK), .rst_b(RST_B), .irq_req(IRQ_REQ), .auto_ack(auto), .ack_dly(dly),
    .ret_cmd(ret), .irq_ack(IRQ_ACK), .irq_reti(IRQ_RETI));
  task chk(input [31:0] s, input [31:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (s !== e) begin
        failures = failures + 1;
        $display("mismatch at %0t: seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task wr(input [4:0] a, input [31:0] d);
    begin
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WE <= 1'b1;
      @(posedge CLK);
      WE <= 1'b0;
    end
  endtask
  task rd(input [4:0] a, input [31:0] e);
    begin
      @(posedge CLK);
      ADDR <= a;
      RE <= 1'b1;
      @(posedge CLK);
      RE <= 1'b0;
      #1 chk(RDATA, e);
    end
  endtask
  // one-cycle source pulse, then room for the flag to reach the outputs
  task ev(input [31:0] b);
    begin
      @(posedge CLK);
      SRC_EVT <= b;
      @(posedge CLK);
      SRC_EVT <= 32'h0;
      repeat (3) @(posedge CLK);
      #1;
    end
  endtask
  task ret_pulse;
    begin
      @(posedge CLK);
      ret <= 1'b1;
      @(posedge CLK);
      ret <= 1'b0;
      repeat (4) @(posedge CLK);
      #1;
    end
  endtask
  task offer(input [3:0] v, input [1:0] l, input [15:0] a);
    chk({IRQ_REQ, IRQ_LEVEL, IRQ_VEC, IRQ_ADDR}, {1'b1, l, v, a});
  endtask
  task end_sim;
    begin
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  initial begin
    #100000;
    failures = failures + 1;
    end_sim;
  end
  initial begin
    failures = 0;
    cmp_count = 0;
    {RST_B, WE, RE, auto, ret, dly, ADDR, WDATA, SRC_EVT} = 0;
    EXT_PIN = 6'h3f;
    repeat (4) @(posedge CLK);
    RST_B <= 1'b1;
    rd(`IPW_REG_ENABLE, 32'h0);
    rd(`IPW_REG_LEVEL, 32'h0);
    rd(`IPW_REG_STBY, 32'h0);
    rd(5'h1c, 32'h0);
    wr(`IPW_REG_ENABLE, 32'hffffffff);
    ev(32'h3c4);
    offer(4'h2, `IPW_LVL_L, 16'h0013);
    wr(`IPW_REG_LEVEL, 32'h8);
    repeat (2) @(posedge CLK);
    #1 offer(4'h3, `IPW_LVL_H, 16'h001b);
    auto = 1'b1;
    repeat (4) @(posedge CLK);
    rd(`IPW_REG_LIST, `IPW_VM3);
    rd(`IPW_REG_STATUS, 32'h43);
    $display("test done: priority");
    auto = 1'b0;
    wr(`IPW_REG_LEVEL, 32'h9);
    ev(32'h1);
    offer(4'h0, `IPW_LVL_X, 16'h0003);
    auto = 1'b1;
    repeat (4) @(posedge CLK);
    rd(`IPW_REG_STATUS, 32'hc0);
    auto = 1'b0;
    wr(`IPW_REG_FLAG, 32'h3c1);
    ret_pulse;
    rd(`IPW_REG_STATUS, 32'h40);
    ret_pulse;
    offer(4'h2, `IPW_LVL_L, 16'h0013);
    wr(`IPW_REG_FLAG, 32'hffffffff);
    $display("test done: nesting");
    // a slow core this time
    auto = 1'b1;
    dly = 4'h3;
    for (i = 0; i < 2; i = i + 1) begin
      ev(i ? `IPW_VM7 : `IPW_VM6);
      repeat (6) @(posedge CLK);
      rd(`IPW_REG_LIST, i ? `IPW_VM7 : `IPW_VM6);
      wr(`IPW_REG_FLAG, 32'hffffffff);
      ret_pulse;
    end
    $display("test done: shared list");
    auto = 1'b0;
    wr(`IPW_REG_ENABLE, 32'h0);
    for (i = 0; i < 3; i = i + 1) begin
      wr(`IPW_REG_STBY, 32'h3);
      #1 chk(stops, 5'h1c);
      ev(32'h1 << (5 + 2 * i));
      chk(CPU_STOP, 32'h0);
    end
    wr(`IPW_REG_STBY, 32'h2);
    #1 chk(stops, 5'h1f);
    ev(32'h80);
    chk(CPU_STOP, 32'h1);
    ev(32'h20000000);
    chk(CPU_STOP, 32'h0);
    // pin three must not end hold; the port source ends it instead
    for (i = 0; i < 6; i = i + 1) begin
      wr(`IPW_REG_STBY, 32'h2);
      EXT_PIN <= ~(6'h1 << i);
      repeat (3) @(posedge CLK);
      #1 chk(WAKE, i != 3);
      repeat (2) @(posedge CLK);
      #1 chk(CPU_STOP, i == 3);
      @(posedge CLK);
      EXT_PIN <= 6'h3f;
      repeat (2) @(posedge CLK);
      if (i == 3)
        ev(32'h20000000);
    end
    // active-high pins: idle pins now count as active and end hold at once
    wr(`IPW_REG_STBY, 32'h3f02);
    @(posedge CLK);
    #1 chk({WAKE, CPU_STOP}, 32'h2);
    wr(`IPW_REG_STBY, 32'h0);
    $display("test done: hold");
    wr(`IPW_REG_FLAG, 32'hffffffff);
    wr(`IPW_REG_ENABLE, 32'hffffffff);
    wr(`IPW_REG_STBY, 32'h1);
    #1 chk(stops, 5'h10);
    ev(32'h40000000);
    chk(CPU_STOP, 32'h0);
    wr(`IPW_REG_STBY, 32'h2);
    #1 chk(CPU_STOP, 32'h1);
    @(posedge CLK);
    RST_B <= 1'b0;
    #1 chk(CPU_STOP, 32'h0);
    @(posedge CLK);
    RST_B <= 1'b1;
    rd(`IPW_REG_STATUS, 32'h0);
    $display("test done: halt and reset");
    end_sim;
  end
endmodule
bind ipw_ctrl ipw_ctrl_properties #(.NSRC(NSRC)) u_props (.CLK, .RST_B, .SRC_EVT, .IRQ_REQ, .IRQ_VEC,
  .IRQ_ADDR, .IRQ_LEVEL, .IRQ_ACK, .CPU_STOP, .PERIPH_STOP, .MAIN_OSC_STOP, .XTAL_OSC_STOP, .BT_IR_STOP, .WAKE);
